// [common/crc_pkg.sv]
// Package of register offsets, fields and types for the CRC engine with scan control.
package crc_pkg;

   // ----------------------------------------------------------------------
   // Register indices (printed offsets are not word aligned)
   // ----------------------------------------------------------------------
   localparam logic [11:0] IDX_DATA_IN = 12'h34e;
   localparam logic [11:0] IDX_SHARED = 12'h352;
   localparam logic [11:0] IDX_MAIN_CTRL = 12'h356;
   localparam logic [11:0] IDX_POLY_LEN = 12'h357;
   localparam logic [11:0] IDX_DATA_LEN = 12'h358;
   localparam logic [11:0] IDX_SCAN_CTRL = 12'h360;
   localparam int ADDR_W = 14;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int MC_EN = 7;
   localparam int MC_RUN = 6;
   localparam int MC_BUSY = 5;
   localparam int MC_ACCM = 4;
   localparam int MC_SEL_HI = 4;
   localparam int MC_SEL_LO = 3;
   localparam int MC_DIR = 1;
   localparam int MC_FULL = 0;
   localparam int SC_EN = 7;
   localparam int SC_TRIG = 6;
   localparam int SC_GO = 5;
   localparam int SC_REGION = 2;
   localparam int SC_BURST = 1;
   localparam int SC_BUSY = 0;
   localparam int LEN_W = 5;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
   localparam logic [7:0] SCAN_CTRL_RST = 8'h04;
   localparam logic [4:0] LEN_RST = 5'h00;
   localparam logic [4:0] ONE5 = 5'h01;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   typedef enum logic [1:0] {
      SEL_RESULT0 = 2'b00,
      SEL_SHIFT = 2'b01,
      SEL_TAPS = 2'b10,
      SEL_RESULT1 = 2'b11
   } overlay_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SHIFT = 1'b1
   } shift_state_e;

   // Avalon-MM request bundle.
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic [3:0] byteenable;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avm_req_s;

   // Configuration handed to the shifter.
   typedef struct packed {
      logic dir_lsb_first;
      logic accm;
      logic [LEN_W-1:0] poly_len;
      logic [LEN_W-1:0] data_len;
      logic [31:0] taps;
   } shift_cfg_s;

endpackage

// [src/crc_engine.sv]
// CRC engine with scan control, reached over Avalon-MM.
//
// Operation
// - Overlay select 11/00 picks result, 10 tap mask, 01 shifter view.
// - Direction bit set shifts right LSB first; clear shifts left MSB first.
// - Data-full flag reads 1 until the word moves into the shifter.
// - Polynomial length field holds width minus one, up to 32 bits.
// - Data length field holds valid bits minus one; only those shift.
// - Data input is 32 bits, four byte lanes, read/write, reset zero.
// - Result is byte writable, top byte most significant, seedable.
// - Shifter view is read-only live contents, reset zero.
// - Tap mask is read/write, reset zero, each bit enables feedback.
// - Result, shifter view and tap mask share one address.
// - Scanner control bit 7 enables the scanner, reset zero.
// - Region bit set targets data EEPROM, clear targets program flash.
// - Hardware clears scan go past end address idle, or on run or enable clear.
`timescale 1ns/1ps
`default_nettype none
module crc_engine
   import crc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // Scanner side
   input wire logic scan_past_end,
   input wire logic scan_cycle_active,
   input wire logic scan_word_valid,
   input wire logic [31:0] scan_word,
   output logic scan_word_ready,
   output logic scan_enable,
   output logic scan_go,
   output logic memory_region_select,
   output logic scan_trigger_enable,
   output logic scan_burst_mode
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] data_in;
      logic full;
      logic [31:0] taps;
      logic [7:0] main_ctrl;
      logic [LEN_W-1:0] poly_len;
      logic [LEN_W-1:0] data_len;
      logic [7:0] scan_ctrl;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
   } regs_s;

   regs_s r_q;
   regs_s r_d;
   avm_req_s req;
   shift_cfg_s cfg;
   logic sh_ready;
   logic sh_busy;
   logic [31:0] sh_acc;
   logic [31:0] sh_view;
   logic acc_wr;
   logic [31:0] acc_wdata;
   logic load;
   logic [11:0] idx;
   logic hit;
   logic wr_now;
   logic rd_now;
   logic take;
   overlay_e sel;

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] byte_merge(input logic [7:0] old,
                                             input logic [7:0] nw,
                                             input logic be0);
      return be0 ? nw : old;
   endfunction

   // ----------------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------------
   crc_shifter u_shifter (
      .mclk(mclk),
      .nrst(nrst),
      .cfg(cfg),
      .enable(r_q.main_ctrl[MC_EN] && r_q.main_ctrl[MC_RUN]),
      .load(load),
      .word(r_q.data_in),
      .ready(sh_ready),
      .busy(sh_busy),
      .acc_wr(acc_wr),
      .acc_wdata(acc_wdata),
      .acc(sh_acc),
      .shift_view(sh_view)
   );

   // ----------------------------------------------------------------------
   // Register file and bus
   // ----------------------------------------------------------------------
   always_comb
   begin
      req = '{address: avs_address, byteenable: avs_byteenable, read: avs_read,
              write: avs_write, writedata: avs_writedata};
      r_d = r_q;
      r_d.ack = 1'b0;
      // Byte address is four times the register index.
      idx = req.address[ADDR_W-1:2];
      hit = (req.address[1:0] == 2'h0) && ((idx == IDX_DATA_IN) || (idx == IDX_SHARED)
            || (idx == IDX_MAIN_CTRL) || (idx == IDX_POLY_LEN)
            || (idx == IDX_DATA_LEN) || (idx == IDX_SCAN_CTRL));
      // One wait cycle. Read data is registered on the first edge; a write lands only on
      // the second, where the master samples waitrequest low.
      take = (req.read || req.write) && !r_q.ack;
      wr_now = req.write && r_q.ack;
      rd_now = req.read && !r_q.ack;
      sel = overlay_e'(r_q.main_ctrl[MC_SEL_HI:MC_SEL_LO]);
      cfg = '{dir_lsb_first: r_q.main_ctrl[MC_DIR], accm: r_q.main_ctrl[MC_ACCM],
              poly_len: r_q.poly_len, data_len: r_q.data_len, taps: r_q.taps};
      acc_wr = 1'b0;
      acc_wdata = sh_acc;
      // The scanner feeds the data word only when software has left it empty.
      scan_word_ready = !r_q.full && r_q.scan_ctrl[SC_GO];
      load = r_q.full && sh_ready;
      if (load)
      begin
         r_d.full = 1'b0;
      end
      if (scan_word_valid && scan_word_ready)
      begin
         r_d.data_in = scan_word;
         r_d.full = 1'b1;
      end
      if (take)
      begin
         r_d.ack = 1'b1;
         r_d.resp = hit ? 2'b00 : 2'b10;
         r_d.rdata = ZERO32;
      end
      if (rd_now && hit)
      begin
         unique case (idx)
            IDX_DATA_IN: r_d.rdata = r_q.data_in;
            IDX_SHARED:
            begin
               unique case (sel)
                  SEL_TAPS: r_d.rdata = r_q.taps;
                  SEL_SHIFT: r_d.rdata = sh_view;
                  SEL_RESULT0, SEL_RESULT1: r_d.rdata = sh_acc;
               endcase
            end
            IDX_MAIN_CTRL: r_d.rdata = {24'h0, r_q.main_ctrl[7:6], sh_busy || r_q.full,
                                        r_q.main_ctrl[4:1], r_q.full};
            IDX_POLY_LEN: r_d.rdata = {27'h0, r_q.poly_len};
            IDX_DATA_LEN: r_d.rdata = {27'h0, r_q.data_len};
            IDX_SCAN_CTRL: r_d.rdata = {24'h0, r_q.scan_ctrl};
            default: r_d.rdata = ZERO32;
         endcase
      end
      if (wr_now && hit)
      begin
         unique case (idx)
            IDX_DATA_IN:
            begin
               r_d.data_in = lane_merge(r_q.data_in, req.writedata, req.byteenable);
               r_d.full = 1'b1;
            end
            IDX_SHARED:
            begin
               unique case (sel)
                  SEL_TAPS: r_d.taps = lane_merge(r_q.taps, req.writedata, req.byteenable);
                  SEL_SHIFT: r_d.taps = r_q.taps;
                  SEL_RESULT0, SEL_RESULT1:
                  begin
                     acc_wr = 1'b1;
                     acc_wdata = lane_merge(sh_acc, req.writedata, req.byteenable);
                  end
               endcase
            end
            IDX_MAIN_CTRL:
            begin
               r_d.main_ctrl = byte_merge(r_q.main_ctrl, req.writedata[7:0], req.byteenable[0]);
               r_d.main_ctrl[MC_BUSY] = 1'b0;
               r_d.main_ctrl[MC_FULL] = 1'b0;
               r_d.main_ctrl[2] = 1'b0;
            end
            IDX_POLY_LEN: r_d.poly_len = req.byteenable[0] ? req.writedata[4:0] : r_q.poly_len;
            IDX_DATA_LEN: r_d.data_len = req.byteenable[0] ? req.writedata[4:0] : r_q.data_len;
            IDX_SCAN_CTRL:
            begin
               r_d.scan_ctrl = byte_merge(r_q.scan_ctrl, req.writedata[7:0], req.byteenable[0]);
               r_d.scan_ctrl[4:3] = 2'b00;
               r_d.scan_ctrl[SC_BUSY] = r_q.scan_ctrl[SC_BUSY];
            end
            default: r_d.taps = r_q.taps;
         endcase
      end
      r_d.scan_ctrl[SC_BUSY] = scan_cycle_active;
      if ((scan_past_end && !scan_cycle_active) || !r_d.main_ctrl[MC_RUN]
          || !r_d.main_ctrl[MC_EN])
      begin
         r_d.scan_ctrl[SC_GO] = 1'b0;
      end
      avs_waitrequest = (req.read || req.write) && !r_q.ack;
      avs_readdata = r_q.rdata;
      avs_response = r_q.resp;
      scan_enable = r_q.scan_ctrl[SC_EN];
      scan_go = r_q.scan_ctrl[SC_GO];
      memory_region_select = r_q.scan_ctrl[SC_REGION];
      scan_trigger_enable = r_q.scan_ctrl[SC_TRIG];
      scan_burst_mode = r_q.scan_ctrl[SC_BURST];
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_q <= '{data_in: WORD_RST, full: 1'b0, taps: WORD_RST, main_ctrl: MAIN_CTRL_RST,
                  poly_len: LEN_RST, data_len: LEN_RST, scan_ctrl: SCAN_CTRL_RST,
                  ack: 1'b0, rdata: WORD_RST, resp: 2'b00};
      end
      else
      begin
         r_q <= r_d;
      end
   end

endmodule
`default_nettype wire

// [src/crc_shifter.sv]
// Bit-serial CRC shifter with programmable length, taps and direction.
`timescale 1ns/1ps
`default_nettype none
module crc_shifter
   import crc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Configuration
   input wire shift_cfg_s cfg,
   input wire logic enable,
   // Word load
   input wire logic load,
   input wire logic [31:0] word,
   output logic ready,
   output logic busy,
   // Accumulator access
   input wire logic acc_wr,
   input wire logic [31:0] acc_wdata,
   output logic [31:0] acc,
   output logic [31:0] shift_view
);

   typedef struct packed {
      shift_state_e st;
      logic [31:0] acc;
      logic [31:0] sh;
      logic [LEN_W-1:0] left;
   } sstate_s;

   sstate_s s_q;
   sstate_s s_d;
   logic fb;
   logic din;
   logic [31:0] mask;

   always_comb
   begin
      s_d = s_q;
      mask = ~(32'hffff_fffe << cfg.poly_len);
      din = cfg.dir_lsb_first ? s_q.sh[0] : s_q.sh[cfg.data_len];
      if (cfg.accm)
      begin
         fb = s_q.acc[cfg.poly_len];
      end
      else
      begin
         fb = s_q.acc[cfg.poly_len] ^ din;
      end
      ready = (s_q.st == ST_IDLE) && enable;
      busy = (s_q.st == ST_SHIFT);
      if (acc_wr)
      begin
         s_d.acc = acc_wdata;
      end
      unique case (s_q.st)
         ST_IDLE:
         begin
            if (load && enable)
            begin
               s_d.sh = word;
               s_d.left = cfg.data_len;
               s_d.st = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (!enable)
            begin
               s_d.st = ST_IDLE;
            end
            else
            begin
               s_d.acc = ({s_q.acc[30:0], (cfg.accm ? din : 1'b0)}
                          ^ (fb ? cfg.taps : ZERO32)) & mask;
               s_d.sh = cfg.dir_lsb_first ? {1'b0, s_q.sh[31:1]} : {s_q.sh[30:0], 1'b0};
               s_d.left = s_q.left - ONE5;
               if (s_q.left == LEN_RST)
               begin
                  s_d.st = ST_IDLE;
               end
            end
         end
      endcase
      acc = s_q.acc;
      shift_view = s_q.sh;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '{st: ST_IDLE, acc: WORD_RST, sh: WORD_RST, left: LEN_RST};
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule
`default_nettype wire

// [test/crc_engine_sva.sv]
// Assertion checker for the CRC engine bus and scanner ports.
`timescale 1ns/1ps
`default_nettype none
module crc_engine_sva
   import crc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // Scanner side
   input wire logic scan_past_end,
   input wire logic scan_cycle_active,
   input wire logic scan_word_valid,
   input wire logic [31:0] scan_word,
   input wire logic scan_word_ready,
   input wire logic scan_enable,
   input wire logic scan_go,
   input wire logic memory_region_select,
   input wire logic scan_trigger_enable,
   input wire logic scan_burst_mode
);
   // ------
   // Helpers
   // ------
   logic req, done, mapped, sc_hit, sc_wr;
   assign req = avs_read | avs_write;
   assign done = req & ~avs_waitrequest;
   assign sc_hit = avs_write & avs_byteenable[0] & (avs_address == {IDX_SCAN_CTRL, 2'h0});
   assign sc_wr = sc_hit & done;
   // Only these aligned byte addresses decode; everything else must be refused.
   assign mapped = avs_address inside {{IDX_DATA_IN, 2'h0}, {IDX_SHARED, 2'h0},
      {IDX_MAIN_CTRL, 2'h0}, {IDX_POLY_LEN, 2'h0}, {IDX_DATA_LEN, 2'h0}, {IDX_SCAN_CTRL, 2'h0}};

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // ------
   // Properties
   // ------
   a_wait_one: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_idle_ready: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest high without a request");
   a_unmapped_err: assert property (done && !mapped |->
      avs_response == 2'h2 && (avs_write || avs_readdata == ZERO32))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (done && mapped |-> avs_response == 2'h0)
      else $error("mapped access refused");
   a_region_write: assert property (sc_wr |=>
      memory_region_select == $past(avs_writedata[SC_REGION])
      && scan_enable == $past(avs_writedata[SC_EN]))
      else $error("scanner enable or region not as written");
   a_mode_write: assert property (sc_wr |=>
      scan_trigger_enable == $past(avs_writedata[SC_TRIG])
      && scan_burst_mode == $past(avs_writedata[SC_BURST]))
      else $error("scanner trigger or burst not as written");
   a_enable_cause: assert property (!$stable(scan_enable) |-> $past(sc_hit))
      else $error("scanner enable changed without a write");
   a_go_clears: assert property (scan_go && scan_past_end && !scan_cycle_active |=> !scan_go)
      else $error("scan go not cleared past end address");
   a_ready_gated: assert property (scan_word_ready |-> scan_go)
      else $error("scanner word ready without scan go");
   a_readdata_hold: assert property (!$stable(avs_readdata) |-> $past(req && avs_waitrequest))
      else $error("read data changed without a request");

   cover property (sc_wr);
   cover property (done && !mapped);
   cover property ($fell(scan_go));
endmodule
bind crc_engine crc_engine_sva u_sva (.*);
`default_nettype wire

// [test/crc_engine_tb_top.sv]
// Self-checking testbench for the CRC engine with scan control.
`timescale 1ns/1ps
`default_nettype none
module crc_engine_tb_top
   import crc_pkg::*;
;
   logic mclk = 1'h0, nrst = 1'h0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic avs_read = 1'h0, avs_write = 1'h0, scan_past_end = 1'h0, scan_cycle_active = 1'h0;
   logic scan_word_valid = 1'h0;
   logic [31:0] avs_writedata = 32'h0, scan_word = 32'h0, avs_readdata, rdata, d, t, r;
   logic [31:0] mdl [3] = '{32'h0, 32'h0, 32'h0};
   logic avs_waitrequest, scan_word_ready, scan_enable, scan_go, memory_region_select;
   logic scan_trigger_enable, scan_burst_mode;
   logic [1:0] avs_response, rresp;
   int mismatches = 0, comparisons = 0, seed = 32'h687f5402, pl, dl;

   always #50 mclk = ~mclk;
   crc_engine u_dut (.*);

   // ------
   // Shared tasks
   // ------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [3:0] be,
         input logic [31:0] wd);
      @(posedge mclk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      @(posedge mclk);
      while (avs_waitrequest === 1'h1) @(posedge mclk);
      rdata = avs_readdata;
      rresp = avs_response;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [3:0] be, input logic [31:0] wd);
      bus(1'h1, {idx, 2'h0}, be, wd);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [3:0] be, input logic [31:0] exp);
      logic [31:0] mk;
      mk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      bus(1'h0, {idx, 2'h0}, be, 32'h0);
      check($sformatf("reg %h", idx), rdata & mk, exp & mk);
   endtask
   task automatic ctrl(input logic [1:0] er, input logic [1:0] sel, input logic dir);
      wr(IDX_MAIN_CTRL, 4'h1, {24'h0, er, 1'h0, sel, 1'h0, dir, 1'h0});
   endtask
   // Bit-serial reference: the accumulator always moves towards its top bit; the
   // direction only picks the data bit order, and accumulate mode feeds data into bit 0.
   function automatic logic [31:0] crc(input logic [31:0] a, input logic [31:0] tp,
         input logic [31:0] dw, input int pl, input int dl, input logic dir, input logic am);
      logic [31:0] m;
      logic fb;
      logic b;
      m = 32'((64'h1 << (pl + 1)) - 64'h1);
      a = a & m;
      for (int i = 0; i <= dl; i++)
      begin
         b = dir ? dw[i] : dw[dl - i];
         fb = a[pl] ^ (b & !am);
         a = ((a << 1) | 32'(b & am)) ^ (fb ? tp : 32'h0);
         a = a & m;
      end
      return a;
   endfunction
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------
   // Tests
   // ------
   initial
   begin
      repeat (10) @(posedge mclk);
      check("scan outs", {scan_enable, scan_go, memory_region_select, scan_trigger_enable, scan_burst_mode}, 32'h4);
      nrst <= 1'h1;
      rd(IDX_DATA_IN, 4'hf, 32'h0);
      rd(IDX_SCAN_CTRL, 4'h1, 32'h4);
      for (int s = 0; s < 4; s++)
      begin
         ctrl(2'h0, 2'(s), 1'h0);
         rd(IDX_SHARED, 4'hf, 32'h0);
      end
      $display("test reset done");
      for (int j = 0; j < 3; j++)
      begin
         ctrl(2'h0, j == 2 ? 2'h2 : 2'h3, 1'h0);
         for (int b = 0; b < 4; b++)
         begin
            d = $random(seed);
            wr(j == 0 ? IDX_DATA_IN : IDX_SHARED, 4'h1 << b, d);
            mdl[j][b*8 +: 8] = d[b*8 +: 8];
            rd(j == 0 ? IDX_DATA_IN : IDX_SHARED, 4'hf, mdl[j]);
         end
      end
      // A write through the shifter view must not land in either neighbour.
      ctrl(2'h0, 2'h1, 1'h0);
      wr(IDX_SHARED, 4'hf, $random(seed));
      for (int s = 0; s < 4; s++)
      begin
         ctrl(2'h0, 2'(s), 1'h0);
         if (s != 1)
            rd(IDX_SHARED, 4'hf, mdl[s == 2 ? 2 : 1]);
      end
      bus(1'h0, 14'h0004, 4'hf, 32'h0);
      check("unmapped resp", 32'(rresp), 32'h2);
      check("unmapped data", rdata, 32'h0);
      $display("test registers done");
      for (int n = 0; n < 6; n++)
      begin
         pl = n == 0 ? 31 : {$random(seed)} % 32;
         dl = n == 1 ? 0 : (n == 0 ? 31 : {$random(seed)} % 32);
         t = $random(seed) | 32'h1;
         r = $random(seed);
         d = $random(seed);
         ctrl(2'h0, 2'h2, n[0]);
         wr(IDX_SHARED, 4'hf, t);
         ctrl(2'h0, 2'h3, n[0]);
         wr(IDX_SHARED, 4'hf, r);
         wr(IDX_POLY_LEN, 4'h1, 32'(pl));
         wr(IDX_DATA_LEN, 4'h1, 32'(dl));
         wr(IDX_DATA_IN, 4'hf, d);
         rd(IDX_MAIN_CTRL, 4'h1, {24'h0, 2'h0, 1'h1, 2'h3, 1'h0, n[0], 1'h1});
         // Overlay code 00 also clears the shared accumulate bit, so both modes run.
         ctrl(2'h3, {2{n[1]}}, n[0]);
         bus(1'h0, {IDX_MAIN_CTRL, 2'h0}, 4'h1, 32'h0);
         for (int k = 0; k < 50 && rdata[MC_BUSY] !== 1'h0; k++)
            bus(1'h0, {IDX_MAIN_CTRL, 2'h0}, 4'h1, 32'h0);
         check("ctrl", 32'(rdata[7:0]), 32'({2'h3, 1'h0, {2{n[1]}}, 1'h0, n[0], 1'h0}));
         rd(IDX_SHARED, 4'hf, crc(r, t, d, pl, dl, n[0], n[1]));
         ctrl(2'h3, 2'h1, n[0]);
         rd(IDX_SHARED, 4'hf, n[0] ? d >> (dl + 1) : d << (dl + 1));
      end
      $display("test crc done");
      ctrl(2'h3, 2'h0, 1'h0);
      wr(IDX_SCAN_CTRL, 4'h1, 32'hc2);
      @(posedge mclk);
      check("scan outs", {scan_enable, scan_go, memory_region_select, scan_trigger_enable, scan_burst_mode}, 32'h13);
      wr(IDX_SCAN_CTRL, 4'h1, 32'he6);
      @(posedge mclk);
      check("scan outs", {scan_enable, scan_go, memory_region_select, scan_trigger_enable, scan_burst_mode}, 32'h1f);
      check("word ready", scan_word_ready, 32'h1);
      scan_cycle_active <= 1'h1;
      scan_past_end <= 1'h1;
      repeat (5) @(posedge mclk);
      check("go held", scan_go, 32'h1);
      scan_cycle_active <= 1'h0;
      repeat (5) @(posedge mclk);
      check("go past end", scan_go, 32'h0);
      rd(IDX_SCAN_CTRL, 4'h1, 32'hc6);
      scan_past_end <= 1'h0;
      wr(IDX_SCAN_CTRL, 4'h1, 32'ha0);
      d = $random(seed);
      scan_word <= d;
      scan_word_valid <= 1'h1;
      @(posedge mclk);
      check("go set", scan_go, 32'h1);
      check("word ready", scan_word_ready, 32'h1);
      scan_word_valid <= 1'h0;
      rd(IDX_DATA_IN, 4'hf, d);
      ctrl(2'h2, 2'h0, 1'h0);
      repeat (2) @(posedge mclk);
      check("go on stop", scan_go, 32'h0);
      $display("test scanner done");
      // A second reset in mid-run must bring data input, main control and scan control back.
      nrst <= 1'h0;
      repeat (2) @(posedge mclk);
      nrst <= 1'h1;
      rd(IDX_DATA_IN, 4'hf, 32'h0);
      rd(IDX_MAIN_CTRL, 4'h1, 32'h0);
      rd(IDX_SCAN_CTRL, 4'h1, 32'h4);
      $display("test reset again done");
      results;
   end

   // The whole run needs under a thousand cycles; twenty thousand means a hang.
   initial
   begin
      #2000000;
      mismatches++;
      results;
   end
endmodule
`default_nettype wire
